/* src/wacd_pkg.sv */
// constants and carrier types for the configuration descriptor generator
package wacd_pkg;
  localparam logic [7:0] CFG_LEN       = 8'h09;
  localparam logic [7:0] CFG_TYPE      = 8'h02;
  localparam logic [7:0] OSC_TYPE      = 8'h07;
  localparam logic [7:0] SEC_LEN       = 8'h05;
  localparam logic [7:0] SEC_TYPE      = 8'h0c;
  localparam logic [7:0] ENC_LEN       = 8'h05;
  localparam logic [7:0] ENC_TYPE      = 8'h0e;
  localparam logic [7:0] IF_LEN        = 8'h09;
  localparam logic [7:0] IF_TYPE       = 8'h04;
  localparam logic [7:0] IF_NUM        = 8'h00;
  localparam logic [7:0] IF_ALT        = 8'h00;
  localparam logic [7:0] IF_NUM_EP     = 8'h03;
  localparam logic [7:0] IF_CLASS      = 8'he0;
  localparam logic [7:0] IF_SUBCLASS   = 8'h02;
  localparam logic [7:0] IF_PROTOCOL   = 8'h01;
  localparam logic [7:0] AUTH_KEY_ZERO = 8'h00;
  localparam logic [7:0] ATTR_RSVD_ONE = 8'h80;
  localparam logic [7:0] ATTR_SELF_PWR = 8'h40;
  localparam logic [7:0] ATTR_WAKEUP   = 8'h20;
  localparam int         MAX_ENC       = 4;
  localparam int         MA_PER_UNIT   = 2;
  localparam logic [15:0] SET_FIXED_LEN = 16'(CFG_LEN) + 16'(SEC_LEN) + 16'(IF_LEN);

  // byte offsets inside each descriptor
  localparam logic [3:0] OFS_LEN         = 4'h0;
  localparam logic [3:0] OFS_TYPE        = 4'h1;
  localparam logic [3:0] CFG_OFS_TOT_LO  = 4'h2;
  localparam logic [3:0] CFG_OFS_TOT_HI  = 4'h3;
  localparam logic [3:0] CFG_OFS_NUM_IF  = 4'h4;
  localparam logic [3:0] CFG_OFS_VALUE   = 4'h5;
  localparam logic [3:0] CFG_OFS_STR     = 4'h6;
  localparam logic [3:0] CFG_OFS_ATTR    = 4'h7;
  localparam logic [3:0] CFG_OFS_POWER   = 4'h8;
  localparam logic [3:0] SEC_OFS_TOT_LO  = 4'h2;
  localparam logic [3:0] SEC_OFS_TOT_HI  = 4'h3;
  localparam logic [3:0] SEC_OFS_COUNT   = 4'h4;
  localparam logic [3:0] ENC_OFS_VALUE   = 4'h2;
  localparam logic [3:0] ENC_OFS_KEY     = 4'h3;
  localparam logic [3:0] ENC_OFS_ATTR    = 4'h4;
  localparam logic [3:0] IF_OFS_NUM      = 4'h2;
  localparam logic [3:0] IF_OFS_ALT      = 4'h3;
  localparam logic [3:0] IF_OFS_NUM_EP   = 4'h4;
  localparam logic [3:0] IF_OFS_CLASS    = 4'h5;
  localparam logic [3:0] IF_OFS_SUBCLASS = 4'h6;
  localparam logic [3:0] IF_OFS_PROTOCOL = 4'h7;
  localparam logic [3:0] IF_OFS_STR      = 4'h8;

  typedef struct packed {
    logic        other_speed;
    logic [15:0] req_len;
  } wacd_req_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       last;
  } wacd_byte_t;

  typedef struct packed {
    logic        self_powered;
    logic        remote_wakeup;
    logic [9:0]  max_power_ma;
    logic [7:0]  num_interfaces;
    logic [7:0]  config_value;
    logic [7:0]  config_str;
    logic [7:0]  iface_str;
    logic [2:0]  num_enc;
  } wacd_cfg_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_SEND = 3'b010,
    ST_DONE = 3'b100
  } wacd_state_t;
endpackage

/* src/wacd_byte_rom.sv */
// combinational map from set position to descriptor byte
module wacd_byte_rom
  import wacd_pkg::*;
(
  input  wire logic [15:0]     pos_in,
  input  wire logic            other_speed_in,
  input  wire wacd_pkg::wacd_cfg_t cfg_in,
  input  wire logic [7:0]      enc_value_in [MAX_ENC],
  output logic [7:0]           data_out,
  output logic [15:0]          total_out
);
  logic [15:0] sec_total;
  logic [15:0] enc_bytes;
  logic [15:0] if_base;
  logic [15:0] rel;
  logic [15:0] enc_rel;
  logic [7:0]  attr;
  logic [7:0]  power;
  logic [2:0]  enc_cnt;

  always_comb
  begin
    enc_cnt   = (cfg_in.num_enc > 3'(MAX_ENC)) ? 3'(MAX_ENC) : cfg_in.num_enc;
    enc_bytes = 16'(enc_cnt) * 16'(ENC_LEN);
    sec_total = 16'(SEC_LEN) + enc_bytes;
    if_base   = 16'(CFG_LEN) + sec_total;
    total_out = SET_FIXED_LEN + enc_bytes;
    attr      = ATTR_RSVD_ONE | (cfg_in.self_powered ? ATTR_SELF_PWR : 8'h00)
              | (cfg_in.remote_wakeup ? ATTR_WAKEUP : 8'h00);
    power     = 8'(cfg_in.max_power_ma / 10'(MA_PER_UNIT));
    rel       = 16'h0000;
    enc_rel   = 16'h0000;
    data_out  = 8'h00;
    if (pos_in < 16'(CFG_LEN))
    begin
      unique case (pos_in[3:0])
        OFS_LEN:        data_out = CFG_LEN;
        OFS_TYPE:       data_out = other_speed_in ? OSC_TYPE : CFG_TYPE;
        CFG_OFS_TOT_LO: data_out = total_out[7:0];
        CFG_OFS_TOT_HI: data_out = total_out[15:8];
        CFG_OFS_NUM_IF: data_out = cfg_in.num_interfaces;
        CFG_OFS_VALUE:  data_out = cfg_in.config_value;
        CFG_OFS_STR:    data_out = cfg_in.config_str;
        CFG_OFS_ATTR:   data_out = attr;
        CFG_OFS_POWER:  data_out = power;
        default:        data_out = 8'h00;
      endcase
    end
    else if (pos_in < 16'(CFG_LEN) + 16'(SEC_LEN))
    begin
      rel = pos_in - 16'(CFG_LEN);
      unique case (rel[3:0])
        OFS_LEN:        data_out = SEC_LEN;
        OFS_TYPE:       data_out = SEC_TYPE;
        SEC_OFS_TOT_LO: data_out = sec_total[7:0];
        SEC_OFS_TOT_HI: data_out = sec_total[15:8];
        SEC_OFS_COUNT:  data_out = 8'(enc_cnt);
        default:        data_out = 8'h00;
      endcase
    end
    else if (pos_in < if_base)
    begin
      enc_rel = pos_in - 16'(CFG_LEN) - 16'(SEC_LEN);
      rel     = enc_rel % 16'(ENC_LEN);
      unique case (rel[3:0])
        OFS_LEN:        data_out = ENC_LEN;
        OFS_TYPE:       data_out = ENC_TYPE;
        ENC_OFS_VALUE:  data_out = enc_value_in[2'(enc_rel / 16'(ENC_LEN))];
        ENC_OFS_KEY:    data_out = AUTH_KEY_ZERO;
        ENC_OFS_ATTR:   data_out = 8'h00;
        default:        data_out = 8'h00;
      endcase
    end
    else
    begin
      rel = pos_in - if_base;
      unique case (rel[3:0])
        OFS_LEN:         data_out = IF_LEN;
        OFS_TYPE:        data_out = IF_TYPE;
        IF_OFS_NUM:      data_out = IF_NUM;
        IF_OFS_ALT:      data_out = IF_ALT;
        IF_OFS_NUM_EP:   data_out = IF_NUM_EP;
        IF_OFS_CLASS:    data_out = IF_CLASS;
        IF_OFS_SUBCLASS: data_out = IF_SUBCLASS;
        IF_OFS_PROTOCOL: data_out = IF_PROTOCOL;
        IF_OFS_STR:      data_out = cfg_in.iface_str;
        default:         data_out = 8'h00;
      endcase
    end
  end
endmodule

/* src/wacd_gen.sv */
// configuration descriptor set generator, one byte per cycle with ready stall
// What this block does
// - configuration descriptor: 9 bytes, type 2, set total
// - attributes: bit7 one, self power, wakeup
// - max power in 2 mA units
// - other speed: type 7, same attr, power
// - security and encryption descriptors inside the set
// - security: 5 bytes, type 12, length, count
// - encryption descriptors follow directly, count as declared, clamped to four
// - encryption auth key index always zero
// - interface: 9 bytes, type 4, three endpoints
// - interface class e0, subclass 02, protocol 01
// - string indices for configuration and interface
module wacd_gen
  import wacd_pkg::*;
(
  input  wire logic                mclk_in,
  input  wire logic                rst_in,
  input  wire logic                req_valid_in,
  input  wire wacd_pkg::wacd_req_t req_in,
  input  wire wacd_pkg::wacd_cfg_t cfg_in,
  input  wire logic [7:0]          enc_value_in [MAX_ENC],
  input  wire logic                byte_ready_in,
  output logic                     busy_out,
  output wacd_pkg::wacd_byte_t     byte_out
);
  typedef struct packed {
    wacd_state_t state;
    logic        other_speed;
    logic [15:0] pos;
    logic [15:0] limit;
    logic        busy;
    wacd_byte_t  out;
  } wacd_gen_state_t;

  wacd_gen_state_t s_reg;
  wacd_gen_state_t s_next;
  logic [7:0]      rom_data;
  logic [15:0]     rom_total;

  wacd_byte_rom u_rom (
    .pos_in         (s_reg.pos),
    .other_speed_in (s_reg.other_speed),
    .cfg_in         (cfg_in),
    .enc_value_in   (enc_value_in),
    .data_out       (rom_data),
    .total_out      (rom_total)
  );

  always_comb
  begin
    s_next = s_reg;
    unique case (s_reg.state)
      ST_IDLE:
      begin
        s_next.out = '0;
        if (req_valid_in)
        begin
          s_next.other_speed = req_in.other_speed;
          s_next.pos         = 16'h0000;
          s_next.limit       = (req_in.req_len < rom_total) ? req_in.req_len : rom_total;
          s_next.busy        = 1'b1;
          s_next.state       = (s_next.limit == 16'h0000) ? ST_DONE : ST_SEND;
        end
      end
      ST_SEND:
      begin
        if (!s_reg.out.valid || byte_ready_in)
        begin
          s_next.out.valid = 1'b1;
          s_next.out.data  = rom_data;
          s_next.out.last  = (s_reg.pos + 16'h0001 == s_reg.limit);
          s_next.pos       = s_reg.pos + 16'h0001;
          if (s_next.out.last)
          begin
            s_next.state = ST_DONE;
          end
        end
      end
      ST_DONE:
      begin
        if (!s_reg.out.valid || byte_ready_in)
        begin
          s_next.out   = '0;
          s_next.busy  = 1'b0;
          s_next.state = ST_IDLE;
        end
      end
      default:
      begin
        s_next.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (rst_in)
    begin
      s_reg       <= '0;
      s_reg.state <= ST_IDLE;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign busy_out = s_reg.busy;
  assign byte_out = s_reg.out;
endmodule

/* bench/wacd_checker.sv */
// port assertions for the descriptor generator
module wacd_checker
  import wacd_pkg::*;
(
  input wire logic                 mclk_in,
  input wire logic                 rst_in,
  input wire logic                 req_valid_in,
  input wire wacd_pkg::wacd_req_t  req_in,
  input wire wacd_pkg::wacd_cfg_t  cfg_in,
  input wire logic                 byte_ready_in,
  input wire logic                 busy_out,
  input wire wacd_pkg::wacd_byte_t byte_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] pos_reg;
  // more than four encryption types are clamped to four
  wire  [15:0] tot = 16'h0017 + 16'h0005 * ((cfg_in.num_enc > 3'h4) ? 16'h0004 : 16'(cfg_in.num_enc));
  wire  [15:0] lim = (req_in.req_len < tot) ? req_in.req_len : tot;
  wire         acc = byte_out.valid && byte_ready_in;
  always_ff @(posedge mclk_in)
    if (rst_in || (req_valid_in && !busy_out))
      pos_reg <= 16'h0000;
    else if (acc)
      pos_reg <= pos_reg + 16'h0001;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  property p_first;
    req_valid_in && !busy_out && req_in.req_len != 16'h0000 |-> ##2 byte_out.valid && byte_out.data == 8'h09;
  endproperty
  a_first: assert property (p_first) else $error("first byte");
  property p_hold;
    byte_out.valid && !byte_ready_in |=> $stable(byte_out);
  endproperty
  a_hold: assert property (p_hold) else $error("byte moved");
  property p_type;
    byte_out.valid && pos_reg == 16'h0001 |-> byte_out.data == (req_in.other_speed ? 8'h07 : 8'h02);
  endproperty
  a_type: assert property (p_type) else $error("type");
  property p_len;
    byte_out.valid && pos_reg == 16'h0002 |-> byte_out.data == tot[7:0];
  endproperty
  a_len: assert property (p_len) else $error("total");
  property p_attr;
    byte_out.valid && pos_reg == 16'h0007 |-> byte_out.data == {1'b1, cfg_in.self_powered, cfg_in.remote_wakeup, 5'h00};
  endproperty
  a_attr: assert property (p_attr) else $error("attr");
  property p_pwr;
    byte_out.valid && pos_reg == 16'h0008 |-> byte_out.data == cfg_in.max_power_ma[8:1];
  endproperty
  a_pwr: assert property (p_pwr) else $error("power");
  property p_last;
    byte_out.valid |-> byte_out.last == (pos_reg + 16'h0001 == lim);
  endproperty
  a_last: assert property (p_last) else $error("last");
  property p_end;
    acc && byte_out.last |=> !byte_out.valid && !busy_out;
  endproperty
  a_end: assert property (p_end) else $error("end");
  c_last: cover property (acc && byte_out.last);
  c_os: cover property (byte_out.valid && req_in.other_speed);
  c_ref: cover property (busy_out && req_valid_in);
endmodule

bind wacd_gen wacd_checker u_chk (.mclk_in, .rst_in, .req_valid_in, .req_in, .cfg_in, .byte_ready_in, .busy_out,
  .byte_out);

/* bench/wacd_host_model.sv */
// host side byte sink, prompt or stalling
module wacd_host_model
(
  input  wire logic mclk_in,
  input  wire logic slow_in,
  output logic      ready_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial ready_out = 1'b0;
  always @(posedge mclk_in) ready_out <= #1 slow_in ? !ready_out : 1'b1;
endmodule

/* bench/wacd_gen_test.sv */
// self-checking bench for the descriptor generator
module wacd_gen_test;
  timeunit 1ns;
  timeprecision 1ps;
  import wacd_pkg::*;
  logic       mclk_in = 1'b0, rst_in = 1'b1, req_valid_in = 1'b0, slow = 1'b0;
  wacd_req_t  req_in = '0;
  wacd_cfg_t  cfg_in = '0;
  logic [7:0] enc_value_in [MAX_ENC] = '{8'h11, 8'h22, 8'h33, 8'h44};
  logic       byte_ready_in, busy_out;
  wacd_byte_t byte_out;
  logic [7:0] exp_q[$], got_q[$];
  int         mismatches = 0, num_checks = 0;
  always #2.5 mclk_in = ~mclk_in;
  wacd_gen dut (.mclk_in, .rst_in, .req_valid_in, .req_in, .cfg_in, .enc_value_in, .byte_ready_in, .busy_out,
    .byte_out);
  wacd_host_model host (.mclk_in(mclk_in), .slow_in(slow), .ready_out(byte_ready_in));
  task automatic check(input bit ok, input string msg);
    num_checks++;
    if (!ok)
    begin
      mismatches++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask
  task automatic run(input string nm, input bit os, input logic [15:0] len, input logic [2:0] ne, input bit dup);
    logic [15:0] tot;
    logic [2:0]  nc;
    int          last_at;
    nc = (ne > 3'(MAX_ENC)) ? 3'(MAX_ENC) : ne;
    tot = 16'h0017 + 16'h0005 * nc;
    last_at = -1;
    got_q = {};
    @(posedge mclk_in);
    #1;
    cfg_in = '{os, !os, 10'h064 + ne, 8'h01, 8'h01, 8'h05, 8'h06, ne};
    req_in = '{os, len};
    req_valid_in = 1'b1;
    exp_q = '{8'h09, os ? 8'h07 : 8'h02, tot[7:0], tot[15:8], 8'h01, 8'h01, 8'h05, {1'b1, os, !os, 5'h00},
      cfg_in.max_power_ma[8:1], 8'h05, 8'h0c, 8'(tot - 16'h0012), 8'h00, 8'(nc)};
    for (int k = 0; k < nc; k++)
      exp_q = {exp_q, 8'h05, ENC_TYPE, enc_value_in[k], 8'h00, 8'h00};
    exp_q = {exp_q, 8'h09, 8'h04, 8'h00, 8'h00, 8'h03, 8'he0, 8'h02, 8'h01, 8'h06};
    while (exp_q.size() > len)
      exp_q.pop_back();
    @(posedge mclk_in);
    #1;
    req_valid_in = 1'b0;
    fork
      if (dup)
      begin
        repeat (4) @(posedge mclk_in);
        #1 req_valid_in = 1'b1;
        @(posedge mclk_in) #1 req_valid_in = 1'b0;
      end
    join_none
    repeat (120)
    begin
      @(negedge mclk_in);
      if (byte_out.valid === 1'b1 && byte_ready_in === 1'b1)
      begin
        if (byte_out.last === 1'b1)
          last_at = got_q.size();
        got_q.push_back(byte_out.data);
      end
    end
    check(busy_out === 1'b0, "busy stuck");
    check(got_q.size() == exp_q.size(), "byte count");
    check(last_at == exp_q.size() - 1, "last flag");
    foreach (exp_q[i])
      if (i < got_q.size())
        check(got_q[i] === exp_q[i], "byte value");
    $display("test %s done", nm);
  endtask
  task automatic t_full;
    run("full", 1'b0, 16'hffff, 3'h4, 1'b0);
  endtask
  task automatic t_other;
    slow = 1'b1;
    run("other", 1'b1, 16'h0040, 3'h3, 1'b0);
    slow = 1'b0;
  endtask
  task automatic t_trunc;
    run("trunc", 1'b0, 16'h001b, 3'h1, 1'b1);
  endtask
  task automatic t_zero;
    run("zero", 1'b1, 16'h0000, 3'h2, 1'b0);
  endtask
  // reset in mid transfer, then a clamped encryption count
  task automatic t_reset;
    @(posedge mclk_in);
    #1;
    req_in = '{1'b0, 16'hffff};
    req_valid_in = 1'b1;
    @(posedge mclk_in);
    #1;
    req_valid_in = 1'b0;
    repeat (6) @(posedge mclk_in);
    #1;
    rst_in = 1'b1;
    repeat (2) @(posedge mclk_in);
    @(negedge mclk_in);
    check(busy_out === 1'b0 && byte_out === '0, "reset state");
    @(posedge mclk_in);
    #1;
    rst_in = 1'b0;
    @(negedge mclk_in);
    check(busy_out === 1'b0 && byte_out === '0, "after reset");
    run("reset", 1'b0, 16'hffff, 3'h7, 1'b0);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge mclk_in);
    #1 rst_in = 1'b0;
    t_full();
    t_other();
    t_trunc();
    t_zero();
    t_reset();
    report_and_stop();
  end
  initial
  begin
    #20000;
    mismatches++;
    report_and_stop();
  end
endmodule
